// File: design/iso_hs_defs.vh
// Constants for the high-speed isochronous descriptor engine.
// Included by every design file; definitions only.
`ifndef ISO_HS_DEFS_VH
`define ISO_HS_DEFS_VH

// ----------------------------------------
// Register word indexes (byte address / 4)
// ----------------------------------------
`define REG_CTRL 3'h0
`define REG_DESC_BASE 3'h1
`define REG_UFRAME 3'h2
`define REG_STATUS 3'h3
`define REG_NEXT_LINK 3'h4
`define REG_LAST_SLOT 3'h5
`define CTRL_FOLLOW 0
`define CTRL_START 1
`define ST_BUSY 0
`define ST_LINK_VALID 1
`define ST_TYPE_LO 2
`define ST_SKIP 4
`define ST_IOC_PEND 5
`define UFRAME_HI 2

// ----------------------------------------
// Descriptor layout
// ----------------------------------------
`define DESC_LAST_WORD 4'hF
`define SLOT_WORD0 4'h1
`define PAGE_WORD0 4'h9
`define LINK_ADDR_LSB 5
`define LINK_TYPE_HI 2
`define LINK_TYPE_LO 1
`define LINK_TERM_BIT 0
`define TYPE_ITD 2'h0
`define TYPE_QH 2'h1
`define TYPE_SITD 2'h2
`define TYPE_FSTN 2'h3
`define SLOT_ACTIVE 31
`define SLOT_BUF_ERR 30
`define SLOT_BABBLE 29
`define SLOT_XACT_ERR 28
`define SLOT_LEN_HI 27
`define SLOT_LEN_LO 16
`define SLOT_IOC 15
`define SLOT_PG_HI 14
`define SLOT_PG_LO 12
`define SLOT_OFS_HI 11
`define MAX_PAGE 3'h6
`define PAGE_LSB 12
`define EP_HI 11
`define EP_LO 8
`define DEV_HI 6
`define DIR_BIT 11
`define MPS_HI 10
`define MULT_HI 1
`define MULT_ONE 2'h1

`endif

// File: design/itd_slot_status.v
// Splits one transaction slot word into its fields and builds its write-back.
// Assumes the status flags are valid while the engine writes the slot back.
`timescale 1ns/1ps
`include "iso_hs_defs.vh"

module itd_slot_status (
   // Slot word and outcome
   input wire [31:0] slot_word_in,
   input wire is_in_in,
   input wire buf_err_in,
   input wire babble_in,
   input wire no_resp_in,
   input wire [11:0] rx_count_in,
   // Decoded fields
   output wire active_out,
   output wire [11:0] length_out,
   output wire ioc_out,
   output wire [2:0] page_select_out,
   output wire [11:0] offset_out,
   output wire [31:0] wback_out
);

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   assign active_out = slot_word_in[`SLOT_ACTIVE];
   assign length_out = slot_word_in[`SLOT_LEN_HI:`SLOT_LEN_LO];
   assign ioc_out = slot_word_in[`SLOT_IOC];
   assign page_select_out = slot_word_in[`SLOT_PG_HI:`SLOT_PG_LO];
   assign offset_out = slot_word_in[`SLOT_OFS_HI:0];

   // ----------------------------------------
   // Write-back word
   // ----------------------------------------
   // Low half is read-only and copied through untouched
   assign wback_out[`SLOT_ACTIVE] = 1'b0;
   assign wback_out[`SLOT_BUF_ERR] = slot_word_in[`SLOT_BUF_ERR] | buf_err_in;
   assign wback_out[`SLOT_BABBLE] = slot_word_in[`SLOT_BABBLE] | babble_in;
   // Missing response only counts against IN traffic
   assign wback_out[`SLOT_XACT_ERR] = slot_word_in[`SLOT_XACT_ERR] |
      (no_resp_in & is_in_in);
   // OUT keeps the programmed length; IN reports what arrived
   assign wback_out[`SLOT_LEN_HI:`SLOT_LEN_LO] = is_in_in ? rx_count_in :
      slot_word_in[`SLOT_LEN_HI:`SLOT_LEN_LO];
   assign wback_out[`SLOT_IOC:0] = slot_word_in[`SLOT_IOC:0];

endmodule // itd_slot_status

// File: design/itd_buf_addr.v
// Builds a packet start address from a page pointer, offset and packet step.
// Assumes the caller has already chosen the page pointer word.
`timescale 1ns/1ps
`include "iso_hs_defs.vh"

module itd_buf_addr (
   // Inputs
   input wire [31:0] page_word_in,
   input wire [11:0] offset_in,
   input wire [11:0] step_in,
   // Address
   output wire [31:0] addr_out
);

   // ----------------------------------------
   // Address build
   // ----------------------------------------
   // Offset sits below the page; later packets of a burst may carry into the next page
   wire [31:0] base = {page_word_in[31:`PAGE_LSB], offset_in};
   assign addr_out = base + {20'h00000, step_in};

endmodule // itd_buf_addr

// File: design/iso_hs_descriptor_engine.v
// High-speed isochronous descriptor engine: fetches, runs and retires one slot.
// Assumes a word memory port acked one word at a time and a same-clock link layer.
`timescale 1ns/1ps
`include "iso_hs_defs.vh"

module iso_hs_descriptor_engine (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Register bus
   input wire [4:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output reg avs_waitrequest_out,
   // Descriptor memory port
   output reg mem_req_out,
   output reg mem_we_out,
   output reg [31:0] mem_addr_out,
   output reg [31:0] mem_wdata_out,
   input wire mem_ack_in,
   input wire [31:0] mem_rdata_in,
   // Transaction request to the link layer
   output reg xact_start_out,
   output reg xact_dir_in_out,
   output reg [31:0] xact_addr_out,
   output reg [11:0] xact_len_out,
   output reg [3:0] xact_endpoint_out,
   output reg [6:0] xact_dev_addr_out,
   output reg [10:0] xact_max_pkt_out,
   // Transaction outcome
   input wire xact_done_in,
   input wire [11:0] xact_count_in,
   input wire xact_babble_in,
   input wire xact_buf_err_in,
   input wire xact_no_resp_in,
   // Interrupt threshold and completion event
   input wire irq_threshold_in,
   output reg ioc_out
);

   localparam S_IDLE = 3'h0;
   localparam S_FETCH = 3'h1;
   localparam S_DECODE = 3'h2;
   localparam S_ISSUE = 3'h3;
   localparam S_WAIT = 3'h4;
   localparam S_WBACK = 3'h5;
   localparam S_FOLLOW = 3'h6;
   // Byte-lane merge shared by every writable register
   function [31:0] be_merge;
      input [31:0] old;
      input [31:0] wdata;
      input [3:0] be;
      integer i;
      begin
         be_merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               be_merge[i*8 +: 8] = wdata[i*8 +: 8];
            end
         end
      end
   endfunction
   // Smaller of remaining bytes and one packet
   function [11:0] pkt_len;
      input [11:0] remain;
      input [10:0] mps;
      begin
         pkt_len = (remain > {1'b0, mps}) ? {1'b0, mps} : remain;
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [2:0] state;
   reg [31:0] desc_word [0:15];
   reg [3:0] word_idx;
   reg [26:0] desc_base;
   reg follow_en;
   reg [2:0] uframe;
   reg [2:0] slot;
   reg [1:0] pkt_idx;
   reg [11:0] step;
   reg [11:0] remain;
   reg [11:0] rx_total;
   reg acc_buf_err;
   reg acc_babble;
   reg acc_no_resp;
   reg slot_skipped;
   reg ioc_pend;
   reg [31:0] last_slot;
   wire [31:0] link_word = desc_word[0];
   wire link_valid = ~link_word[`LINK_TERM_BIT];
   wire [1:0] link_type = link_word[`LINK_TYPE_HI:`LINK_TYPE_LO];
   wire [31:0] link_addr = {link_word[31:`LINK_ADDR_LSB], 5'h00};
   wire busy = (state != S_IDLE);
   // ----------------------------------------
   // Slot and endpoint decode
   // ----------------------------------------
   wire [3:0] slot_word_idx = `SLOT_WORD0 + {1'b0, slot};
   wire [31:0] slot_word = desc_word[slot_word_idx];
   wire [31:0] page0 = desc_word[`PAGE_WORD0];
   wire [31:0] page1 = desc_word[`PAGE_WORD0 + 4'h1];
   wire [31:0] page2 = desc_word[`PAGE_WORD0 + 4'h2];
   wire is_in = page1[`DIR_BIT];
   wire [10:0] mps = page1[`MPS_HI:0];
   wire [1:0] mult_code = page2[`MULT_HI:0];
   // Reserved code 00 is run as a single transaction
   wire [1:0] mult = (mult_code == 2'h0) ? `MULT_ONE : mult_code;
   wire s_ioc;
   wire [2:0] s_pg;
   wire [11:0] s_ofs;
   wire [31:0] s_wback;
   // Out-of-range page select is clamped to the last pointer
   wire [2:0] pg_eff = (s_pg > `MAX_PAGE) ? `MAX_PAGE : s_pg;
   wire [31:0] page_sel = desc_word[`PAGE_WORD0 + {1'b0, pg_eff}];
   wire [31:0] pkt_addr;

   itd_slot_status u_slot (
      .slot_word_in(slot_word),
      .is_in_in(is_in),
      .buf_err_in(acc_buf_err),
      .babble_in(acc_babble),
      .no_resp_in(acc_no_resp),
      .rx_count_in(rx_total),
      .active_out(),
      .length_out(),
      .ioc_out(s_ioc),
      .page_select_out(s_pg),
      .offset_out(s_ofs),
      .wback_out(s_wback)
   );
   itd_buf_addr u_addr (
      .page_word_in(page_sel),
      .offset_in(s_ofs),
      .step_in(step),
      .addr_out(pkt_addr)
   );

   // ----------------------------------------
   // Register bus slave
   // ----------------------------------------
   // One wait cycle per access keeps read data registered
   wire bus_req = avs_read_in | avs_write_in;
   wire bus_take = bus_req & ~avs_waitrequest_out;
   wire [2:0] reg_idx = avs_address_in[4:2];
   wire [31:0] ctrl_word = {30'h0, 1'b0, follow_en};
   wire [31:0] new_ctrl = be_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
   wire [31:0] new_base = be_merge({desc_base, 5'h00}, avs_writedata_in, avs_byteenable_in);
   wire [31:0] new_ufr = be_merge({29'h0, uframe}, avs_writedata_in, avs_byteenable_in);
   wire start_req = bus_take & avs_write_in & (reg_idx == `REG_CTRL) &
      new_ctrl[`CTRL_START];
   wire [31:0] status_word = {26'h0, ioc_pend, slot_skipped, link_type, link_valid, busy};
   reg [31:0] next_readdata;
   // Read mux; unmapped words read as zero
   always @* begin
      case (reg_idx)
         `REG_CTRL: next_readdata = ctrl_word;
         `REG_DESC_BASE: next_readdata = {desc_base, 5'h00};
         `REG_UFRAME: next_readdata = {29'h0, uframe};
         `REG_STATUS: next_readdata = status_word;
         `REG_NEXT_LINK: next_readdata = link_addr;
         `REG_LAST_SLOT: next_readdata = last_slot;
         default: next_readdata = 32'h00000000;
      endcase
   end
   // Handshake and register writes
   always @(posedge clk_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h00000000;
         follow_en <= 1'b0;
         uframe <= 3'h0;
      end else begin
         avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
         if (bus_req & avs_waitrequest_out) begin
            avs_readdata_out <= avs_read_in ? next_readdata : 32'h00000000;
         end
         if (bus_take & avs_write_in) begin
            case (reg_idx)
               `REG_CTRL: follow_en <= new_ctrl[`CTRL_FOLLOW];
               `REG_UFRAME: uframe <= new_ufr[`UFRAME_HI:0];
               default: follow_en <= follow_en;
            endcase
         end
      end
   end
   // ----------------------------------------
   // Descriptor engine
   // ----------------------------------------
   wire [31:0] desc_addr = {desc_base, 5'h00};
   wire [11:0] rx_sum = rx_total + xact_count_in;
   wire last_pkt = ({1'b0, pkt_idx} + 3'h1 >= {1'b0, mult}) ||
      (is_in ? (xact_count_in < {1'b0, mps}) : (remain <= {1'b0, mps}));
   always @(posedge clk_in) begin
      if (rst_in) begin
         state <= S_IDLE;
         word_idx <= 4'h0;
         desc_base <= 27'h0;
         desc_word[0] <= 32'h00000000; // Status reads a valid iTD link, not unknowns
         slot <= 3'h0;
         pkt_idx <= 2'h0;
         step <= 12'h000;
         remain <= 12'h000;
         rx_total <= 12'h000;
         acc_buf_err <= 1'b0;
         acc_babble <= 1'b0;
         acc_no_resp <= 1'b0;
         slot_skipped <= 1'b0;
         last_slot <= 32'h00000000;
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= 32'h00000000;
         mem_wdata_out <= 32'h00000000;
         xact_start_out <= 1'b0;
         xact_dir_in_out <= 1'b0;
         xact_addr_out <= 32'h00000000;
         xact_len_out <= 12'h000;
         xact_endpoint_out <= 4'h0;
         xact_dev_addr_out <= 7'h00;
         xact_max_pkt_out <= 11'h000;
      end else begin
         xact_start_out <= 1'b0;
         case (state)
            S_IDLE: begin
               // Base may only be written over the bus while idle
               if (bus_take & avs_write_in & (reg_idx == `REG_DESC_BASE)) begin
                  desc_base <= new_base[31:`LINK_ADDR_LSB];
               end
               if (start_req) begin
                  word_idx <= 4'h0;
                  state <= S_FETCH;
               end
            end
            S_FETCH: begin
               // Request dropped for a cycle after every ack
               if (mem_req_out & mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  desc_word[word_idx] <= mem_rdata_in;
                  if (word_idx == `DESC_LAST_WORD) begin
                     state <= S_DECODE;
                  end else begin
                     word_idx <= word_idx + 4'h1;
                  end
               end else if (!mem_req_out) begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b0;
                  mem_addr_out <= desc_addr + {26'h0, word_idx, 2'h0};
               end
            end
            S_DECODE: begin
               slot <= uframe;
               state <= S_ISSUE;
               pkt_idx <= 2'h0;
               step <= 12'h000;
               rx_total <= 12'h000;
               acc_buf_err <= 1'b0;
               acc_babble <= 1'b0;
               acc_no_resp <= 1'b0;
               slot_skipped <= 1'b0;
               if (!desc_word[`SLOT_WORD0 + {1'b0, uframe}][`SLOT_ACTIVE]) begin
                  slot_skipped <= 1'b1;
                  state <= S_FOLLOW;
               end else begin
                  remain <= desc_word[`SLOT_WORD0 + {1'b0, uframe}]
                     [`SLOT_LEN_HI:`SLOT_LEN_LO];
               end
            end
            S_ISSUE: begin
               // Slot fields joined with the endpoint fields of pages 0 and 1
               xact_start_out <= 1'b1;
               xact_addr_out <= pkt_addr;
               xact_dir_in_out <= is_in;
               xact_len_out <= is_in ? {1'b0, mps} : pkt_len(remain, mps);
               xact_endpoint_out <= page0[`EP_HI:`EP_LO];
               xact_dev_addr_out <= page0[`DEV_HI:0];
               xact_max_pkt_out <= mps;
               state <= S_WAIT;
            end
            S_WAIT: begin
               if (xact_done_in) begin
                  rx_total <= rx_sum;
                  acc_buf_err <= acc_buf_err | xact_buf_err_in;
                  // More than one packet's worth on IN is babble
                  acc_babble <= acc_babble | xact_babble_in |
                     (is_in & (xact_count_in > {1'b0, mps}));
                  acc_no_resp <= acc_no_resp | xact_no_resp_in;
                  remain <= remain - pkt_len(remain, mps);
                  step <= step + {1'b0, mps};
                  pkt_idx <= pkt_idx + 2'h1;
                  state <= last_pkt ? S_WBACK : S_ISSUE;
               end
            end
            S_WBACK: begin
               if (mem_req_out & mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  mem_we_out <= 1'b0;
                  last_slot <= s_wback;
                  desc_word[slot_word_idx] <= s_wback;
                  state <= S_FOLLOW;
               end else if (!mem_req_out) begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b1;
                  mem_addr_out <= desc_addr + {26'h0, slot_word_idx, 2'h0};
                  mem_wdata_out <= s_wback;
               end
            end
            S_FOLLOW: begin
               // Only an iTD is processed here; other types are left to the walker
               if (follow_en & link_valid & (link_type == `TYPE_ITD)) begin
                  desc_base <= link_addr[31:`LINK_ADDR_LSB];
                  word_idx <= 4'h0;
                  state <= S_FETCH;
               end else begin
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Completion interrupt
   // ----------------------------------------
   // A completion in the threshold cycle stays pending for the next one
   wire ioc_set = (state == S_WBACK) & mem_req_out & mem_ack_in & s_ioc;
   always @(posedge clk_in) begin
      if (rst_in) begin
         ioc_pend <= 1'b0;
         ioc_out <= 1'b0;
      end else begin
         ioc_out <= irq_threshold_in & ioc_pend;
         if (ioc_set) begin
            ioc_pend <= 1'b1;
         end else if (irq_threshold_in) begin
            ioc_pend <= 1'b0;
         end
      end
   end
endmodule // iso_hs_descriptor_engine

// File: dv/iso_hs_engine_assertions.sv
// Checker for the isochronous descriptor engine: handshakes, pulses, lengths.
// Sees only top-level ports; bound to every instance of the engine.
`timescale 1ns/1ps
module iso_hs_engine_checker (
   // Clock, reset and register bus
   input wire clk_in,
   input wire rst_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire avs_waitrequest_out,
   // Memory port
   input wire mem_req_out,
   input wire mem_we_out,
   input wire [31:0] mem_addr_out,
   input wire mem_ack_in,
   // Transactions and interrupt
   input wire xact_start_out,
   input wire xact_dir_in_out,
   input wire [11:0] xact_len_out,
   input wire [10:0] xact_max_pkt_out,
   input wire irq_threshold_in,
   input wire ioc_out
);
   // ----------------------------------------
   // Properties, all in the one clock domain
   // ----------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   AST_BUS_ANSWER: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("bus request not answered next cycle");
   AST_BUS_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low too long");
   AST_BUS_QUIET: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
      |=> avs_waitrequest_out) else $error("accept without request");
   // A memory request must not move until acked, or the word lands elsewhere
   AST_MEM_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
      && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("memory request moved");
   AST_MEM_DROP: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
      else $error("memory request not dropped after ack");
   AST_START_PULSE: assert property (xact_start_out |=> !xact_start_out)
      else $error("start longer than one cycle");
   AST_NO_XACT_IN_FETCH: assert property (mem_req_out |-> !xact_start_out)
      else $error("transaction started during memory access");
   AST_IN_LEN: assert property (xact_start_out && xact_dir_in_out
      |-> xact_len_out == {1'b0, xact_max_pkt_out}) else $error("IN length not max packet");
   AST_OUT_LEN: assert property (xact_start_out && !xact_dir_in_out
      |-> xact_len_out <= {1'b0, xact_max_pkt_out}) else $error("OUT packet too long");
   AST_IOC_CAUSE: assert property (ioc_out |-> $past(irq_threshold_in))
      else $error("interrupt without threshold");
   AST_FIELDS_HOLD: assert property (!xact_start_out
      |-> $stable(xact_dir_in_out) && $stable(xact_len_out)) else $error("fields moved");
   cover property (xact_start_out && xact_dir_in_out);
   cover property (xact_start_out && !xact_dir_in_out);
   cover property (mem_req_out && mem_we_out && mem_ack_in);
   cover property (ioc_out);
endmodule // iso_hs_engine_checker

bind iso_hs_descriptor_engine iso_hs_engine_checker chk_i (.clk_in, .rst_in, .avs_read_in,
   .avs_write_in, .avs_waitrequest_out, .mem_req_out, .mem_we_out, .mem_addr_out,
   .mem_ack_in, .xact_start_out, .xact_dir_in_out, .xact_len_out, .xact_max_pkt_out,
   .irq_threshold_in, .ioc_out);

// File: dv/itd_far_side.sv
// Far side model: word memory holding descriptors, and a link layer.
// Assumes one clock; memory latency alternates between prompt and slow, and the link takes the memory's current one.
`timescale 1ns/1ps
module itd_far_side (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Memory port
   input wire mem_req_in,
   input wire mem_we_in,
   input wire [31:0] mem_addr_in,
   input wire [31:0] mem_wdata_in,
   output reg mem_ack_out,
   output reg [31:0] mem_rdata_out,
   // Link layer
   input wire xact_start_in,
   input wire [11:0] rsp_count_in,
   input wire [2:0] rsp_flags_in,
   output reg xact_done_out,
   output reg [11:0] xact_count_out,
   output reg [2:0] xact_flags_out
);
   reg [31:0] mem [0:63];
   reg [1:0] wait_cnt;
   reg slow;
   reg [2:0] link_cnt;
   // Memory: one ack per request; data bus toggles when not answering
   always @(posedge clk_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      if (rst_in) begin
         wait_cnt <= 2'h0;
         slow <= 1'b0;
         mem_rdata_out <= 32'h0;
      end else if (mem_req_in && !mem_ack_out) begin
         if (wait_cnt == {slow, 1'b0}) begin
            mem_ack_out <= 1'b1;
            wait_cnt <= 2'h0;
            slow <= ~slow;
            if (mem_we_in)
               mem[mem_addr_in[7:2]] <= mem_wdata_in;
            else
               mem_rdata_out <= mem[mem_addr_in[7:2]];
         end else
            wait_cnt <= wait_cnt + 2'h1;
      end
   end
   // Link: one done per start; flags are only meaningful with done
   always @(posedge clk_in) begin
      xact_done_out <= 1'b0;
      xact_flags_out <= ~rsp_flags_in;
      xact_count_out <= ~rsp_count_in;
      if (rst_in)
         link_cnt <= 3'h0;
      else if (xact_start_in)
         link_cnt <= slow ? 3'h4 : 3'h1;
      else if (link_cnt == 3'h1) begin
         xact_done_out <= 1'b1;
         xact_flags_out <= rsp_flags_in;
         xact_count_out <= rsp_count_in;
         link_cnt <= 3'h0;
      end else if (link_cnt != 3'h0)
         link_cnt <= link_cnt - 3'h1;
   end
endmodule // itd_far_side

// File: dv/tb.sv
// Testbench: registers, IN and OUT slots, skipped slot, completion interrupt.
// Assumes descriptors at byte 0x40 of the far side memory.
`timescale 1ns/1ps
module tb;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [4:0] avs_address_in = 5'h00;
   reg avs_read_in = 1'b0;
   reg avs_write_in = 1'b0;
   reg [31:0] avs_writedata_in = 32'h0;
   reg [3:0] avs_byteenable_in = 4'hF;
   reg irq_threshold_in = 1'b0;
   reg [11:0] rsp_count = 12'h000;
   reg [2:0] rsp_flags = 3'h0;
   wire [31:0] avs_readdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in, xact_addr_out;
   wire avs_waitrequest_out, mem_req_out, mem_we_out, mem_ack_in, xact_start_out;
   wire xact_dir_in_out, xact_done_in, ioc_out;
   wire [2:0] flags;
   wire [11:0] xact_len_out, xact_count_in;
   wire [3:0] xact_endpoint_out;
   wire [6:0] xact_dev_addr_out;
   wire [10:0] xact_max_pkt_out;
   integer num_errors = 0, checks = 0, n_start = 0, i;
   reg [31:0] cap_addr [0:3];
   reg [11:0] cap_len [0:3];
   reg [31:0] q;
   iso_hs_descriptor_engine iso_hs_descriptor_engine_i (.clk_in, .rst_in, .avs_address_in,
      .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
      .avs_waitrequest_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out,
      .mem_ack_in, .mem_rdata_in, .xact_start_out, .xact_dir_in_out, .xact_addr_out,
      .xact_len_out, .xact_endpoint_out, .xact_dev_addr_out, .xact_max_pkt_out,
      .xact_done_in, .xact_count_in, .xact_babble_in(flags[1]), .xact_buf_err_in(flags[2]),
      .xact_no_resp_in(flags[0]), .irq_threshold_in, .ioc_out);
   itd_far_side itd_far_side_i (.clk_in, .rst_in, .mem_req_in(mem_req_out),
      .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in), .xact_start_in(xact_start_out),
      .rsp_count_in(rsp_count), .rsp_flags_in(rsp_flags), .xact_done_out(xact_done_in),
      .xact_count_out(xact_count_in), .xact_flags_out(flags));
   initial forever #2.5 clk_in = ~clk_in;
   // Record every transaction request as it is issued
   always @(posedge clk_in) if (xact_start_out === 1'b1) begin
      cap_addr[n_start[1:0]] <= xact_addr_out;
      cap_len[n_start[1:0]] <= xact_len_out;
      n_start <= n_start + 1;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One Avalon access; request held until waitrequest is sampled low
   task bus(input rd, input [4:0] a, input [31:0] d, input [3:0] be);
      integer n;
      begin
         n = 0;
         @(posedge clk_in);
         avs_read_in <= rd;
         avs_write_in <= !rd;
         avs_address_in <= a;
         avs_writedata_in <= d;
         avs_byteenable_in <= be;
         @(posedge clk_in);
         while (avs_waitrequest_out !== 1'b0 && n < 100) begin
            @(posedge clk_in);
            n = n + 1;
         end
         if (n == 100) chk(32'h0, 32'h1);
         q = avs_readdata_out;
         avs_read_in <= 1'b0;
         avs_write_in <= 1'b0;
      end
   endtask
   task rd(input [4:0] a, input [31:0] e);
      begin
         bus(1'b1, a, 32'h0, 4'hF);
         chk(q, e);
      end
   endtask
   task wr(input [4:0] a, input [31:0] d);
      bus(1'b0, a, d, 4'hF);
   endtask
   // Descriptor at word 16; pages 3 to 6 keep their low 12 bits zero
   task load(input [31:0] lk, input [2:0] s, input [31:0] sw, p0, p1, p2);
      begin
         for (i = 0; i < 16; i = i + 1)
            itd_far_side_i.mem[16 + i] = (i > 11) ? i << 12 : 32'h0;
         itd_far_side_i.mem[16] = lk;
         itd_far_side_i.mem[17 + s] = sw;
         itd_far_side_i.mem[25] = p0;
         itd_far_side_i.mem[26] = p1;
         itd_far_side_i.mem[27] = p2;
      end
   endtask
   task run(input [2:0] s, input follow);
      begin
         wr(5'h08, {29'h0, s});
         wr(5'h00, {30'h0, 1'b1, follow});
         q = 32'h1;
         for (i = 0; i < 100 && q[0] !== 1'b0; i = i + 1) bus(1'b1, 5'h0C, 32'h0, 4'hF);
      end
   endtask
   task pulse(input e);
      begin
         @(posedge clk_in);
         irq_threshold_in <= 1'b1;
         @(posedge clk_in);
         irq_threshold_in <= 1'b0;
         #1 chk(ioc_out, e);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", checks, num_errors);
         if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_in);
      chk(32'h0, 32'h1);
      wrap_up;
   end
   initial begin
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(5'h00, 32'h0);
      rd(5'h0C, 32'h2);
      wr(5'h1C, 32'hFFFF_FFFF);
      rd(5'h1C, 32'h0);
      bus(1'b0, 5'h04, 32'hFFFF_FFFF, 4'h1);
      rd(5'h04, 32'hE0);
      wr(5'h04, 32'h40);
      $display("test registers done");
      // IN slot 2 with every fault flag, short packet, interrupt on complete
      load(32'h11A, 2, 32'h8400_9010, 32'h1_052A, 32'h2_0A00, 32'h3_0001);
      rsp_count <= 12'h020;
      rsp_flags <= 3'h7;
      run(2, 1'b0);
      chk(n_start, 1);
      chk(cap_addr[0], 32'h2_0010);
      chk({20'h0, cap_len[0]}, 32'h200);
      chk({xact_dir_in_out, xact_endpoint_out, xact_dev_addr_out, xact_max_pkt_out},
         {9'h0, 1'b1, 4'h5, 7'h2A, 11'h200});
      chk(itd_far_side_i.mem[19], 32'h7020_9010);
      rd(5'h14, 32'h7020_9010);
      rd(5'h10, 32'h100);
      rd(5'h0C, 32'h26);
      pulse(1'b1);
      $display("test in slot done");
      // OUT slot 7, three packets, no response must not flag an OUT
      load(32'h204, 7, 32'h8500_3100, 32'h1_052A, 32'h2_0200, 32'h3_0003);
      rsp_flags <= 3'h1;
      run(7, 1'b0);
      chk(n_start, 4);
      for (i = 1; i < 4; i = i + 1) begin
         chk(cap_addr[i], 32'hC100 + (i - 1) * 32'h200);
         chk({20'h0, cap_len[i]}, (i == 3) ? 32'h100 : 32'h200);
      end
      chk(itd_far_side_i.mem[24], 32'h0500_3100);
      rd(5'h0C, 32'hA);
      pulse(1'b0);
      $display("test out slot done");
      // Inactive slot 0, terminated span-node link with follow enabled
      load(32'h307, 0, 32'h0010_0000, 32'h1_052A, 32'h2_0200, 32'h3_0003);
      run(0, 1'b1);
      chk(n_start, 4);
      chk(itd_far_side_i.mem[17], 32'h0010_0000);
      rd(5'h0C, 32'h1C);
      rd(5'h10, 32'h300);
      $display("test skipped slot done");
      wrap_up;
   end
endmodule // tb
